//--- hw/rps_defines.svh
// offsets, field positions, codes and reset values of the pin remapper
// Functional notes
// - selector code zero ties input to ground
// - selector code one feeds comparator one output
// - top code selects pin 181, codes 2 to 180 by pin number, codes above it tie to ground
// - spi2 select selector in low byte
// - can1 receive selector in low byte
// - pwm sync one selector in high byte
// - dead-time comp one selector in high byte
// - one register: comp three high, two low
// - sent one selector in high byte
// - sent two selector in low byte
// - unused bits ignore writes, read zero
// - output register holds two six-bit function fields
// - output bits 15:14 and 7:6 unimplemented
// - pins paired 20/35, 36/37, 38/39, 40/41
// - all selectors clear to zero at reset
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH

// register word indices on the local bus
`define RPS_REG_SPI2    4'h0
`define RPS_REG_CAN1    4'h1
`define RPS_REG_SYNC    4'h2
`define RPS_REG_DTC1    4'h3
`define RPS_REG_DTC23   4'h4
`define RPS_REG_SENT1   4'h5
`define RPS_REG_SENT2   4'h6
`define RPS_REG_OUT0    4'h7
`define RPS_NUM_OUT_REG 4

// slots of the input selector array
`define RPS_SEL_SPI2  0
`define RPS_SEL_CAN1  1
`define RPS_SEL_SYNC  2
`define RPS_SEL_DTC1  3
`define RPS_SEL_DTC2  4
`define RPS_SEL_DTC3  5
`define RPS_SEL_SENT1 6
`define RPS_SEL_SENT2 7
`define RPS_NUM_IN    8
`define RPS_NUM_PIN   8

// field positions
`define RPS_LO_BYTE   7:0
`define RPS_HI_BYTE   15:8
`define RPS_OUT_LO    5:0
`define RPS_OUT_HI    13:8

// input selector codes
`define RPS_CODE_GND  8'h00
`define RPS_CODE_CMP  8'h01
`define RPS_CODE_MAX  8'hB5
`define RPS_NUM_RPIN  182
`define RPS_FUNC_OFF  6'h00
`define RPS_NUM_FUNC  64

// reset values
`define RPS_SEL_RST   8'h00
`define RPS_FUNC_RST  6'h00
`define RPS_RD_ZERO   16'h0000

`endif

//--- hw/rps_pkg.sv
// types of the pin remapper
package rps_pkg;

	// register access from software
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        we;
		logic        re;
	} rps_bus_req_t;

	// routed peripheral inputs, slot 0 in the low bit
	typedef struct packed {
		logic sent_rx_two_in;
		logic sent_rx_one_in;
		logic deadtime_comp_three_in;
		logic deadtime_comp_two_in;
		logic deadtime_comp_one_in;
		logic pwm_sync_one_in;
		logic can1_receive_in;
		logic spi2_target_select_in;
	} rps_periph_in_t;

	// whole module state
	typedef struct packed {
		logic [7:0][7:0] sel_in;
		logic [7:0][5:0] sel_out;
		logic [15:0]     rdata;
		rps_periph_in_t  route;
		logic [7:0]      pin_out;
		logic [7:0]      pin_oe;
	} rps_state_t;

endpackage : rps_pkg

//--- hw/rps_top.sv
// remappable pin select: selector registers and routing
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "rps_defines.svh"

module rps_top (
	input  wire logic                     clock,              // 250 MHz
	input  wire logic                     nrst,               // async reset, low
	input  wire logic                     ce,                 // freezes state when low
	input  wire rps_pkg::rps_bus_req_t    bus_req,            // register request
	output logic [15:0]                   bus_rdata,          // read data, next cycle
	input  wire logic [`RPS_NUM_RPIN-1:0] remappable_pin,     // pin levels by number
	input  wire logic                     comparator_one_out, // comparator 1 level
	input  wire logic [`RPS_NUM_FUNC-1:0] periph_func,        // output functions by code
	output rps_pkg::rps_periph_in_t       periph_in,          // routed peripheral inputs
	output logic [7:0]                    out_pin,            // pins 20,35..41 levels
	output logic [7:0]                    out_pin_oe          // high when function set
);

	rps_pkg::rps_state_t st_ff;
	rps_pkg::rps_state_t nxt_st;

	// input source decode: ground, comparator, or pin by number
	function automatic logic in_route(
		input logic [7:0]                    sel,
		input logic [`RPS_NUM_RPIN-1:0]      pins,
		input logic                          cmp
	);
		logic v;
		v = 1'b0;
		if (sel == `RPS_CODE_GND) begin
			v = 1'b0;
		end else if (sel == `RPS_CODE_CMP) begin
			v = cmp;
		end else if (sel <= `RPS_CODE_MAX) begin
			v = pins[sel];
		end
		return v;
	endfunction : in_route

	// output function decode: code zero leaves the pin idle
	function automatic logic out_route(
		input logic [5:0]                f,
		input logic [`RPS_NUM_FUNC-1:0]  funcs
	);
		return (f == `RPS_FUNC_OFF) ? 1'b0 : funcs[f];
	endfunction : out_route

	// register read image, unused bits zero
	function automatic logic [15:0] reg_read(
		input logic [3:0]          idx,
		input rps_pkg::rps_state_t s
	);
		logic [15:0] r;
		r = `RPS_RD_ZERO;
		case (idx)
			`RPS_REG_SPI2: begin
				r[`RPS_LO_BYTE] = s.sel_in[`RPS_SEL_SPI2];
			end
			`RPS_REG_CAN1: begin
				r[`RPS_LO_BYTE] = s.sel_in[`RPS_SEL_CAN1];
			end
			`RPS_REG_SYNC: begin
				r[`RPS_HI_BYTE] = s.sel_in[`RPS_SEL_SYNC];
			end
			`RPS_REG_DTC1: begin
				r[`RPS_HI_BYTE] = s.sel_in[`RPS_SEL_DTC1];
			end
			`RPS_REG_DTC23: begin
				r[`RPS_HI_BYTE] = s.sel_in[`RPS_SEL_DTC3];
				r[`RPS_LO_BYTE] = s.sel_in[`RPS_SEL_DTC2];
			end
			`RPS_REG_SENT1: begin
				r[`RPS_HI_BYTE] = s.sel_in[`RPS_SEL_SENT1];
			end
			`RPS_REG_SENT2: begin
				r[`RPS_LO_BYTE] = s.sel_in[`RPS_SEL_SENT2];
			end
			default: begin
				// output pairs, bits 15:14 and 7:6 stay zero
				for (int j = 0; j < `RPS_NUM_OUT_REG; j++) begin
					if (idx == 4'(`RPS_REG_OUT0 + j)) begin
						r[`RPS_OUT_HI] = s.sel_out[2*j+1];
						r[`RPS_OUT_LO] = s.sel_out[2*j];
					end
				end
			end
		endcase
		return r;
	endfunction : reg_read

	// next state: register writes, read data, routing
	always_comb begin
		nxt_st = st_ff;
		if (bus_req.we) begin
			case (bus_req.addr)
				`RPS_REG_SPI2: begin
					nxt_st.sel_in[`RPS_SEL_SPI2] = bus_req.wdata[`RPS_LO_BYTE];
				end
				`RPS_REG_CAN1: begin
					nxt_st.sel_in[`RPS_SEL_CAN1] = bus_req.wdata[`RPS_LO_BYTE];
				end
				`RPS_REG_SYNC: begin
					nxt_st.sel_in[`RPS_SEL_SYNC] = bus_req.wdata[`RPS_HI_BYTE];
				end
				`RPS_REG_DTC1: begin
					nxt_st.sel_in[`RPS_SEL_DTC1] = bus_req.wdata[`RPS_HI_BYTE];
				end
				`RPS_REG_DTC23: begin
					nxt_st.sel_in[`RPS_SEL_DTC3] = bus_req.wdata[`RPS_HI_BYTE];
					nxt_st.sel_in[`RPS_SEL_DTC2] = bus_req.wdata[`RPS_LO_BYTE];
				end
				`RPS_REG_SENT1: begin
					nxt_st.sel_in[`RPS_SEL_SENT1] = bus_req.wdata[`RPS_HI_BYTE];
				end
				`RPS_REG_SENT2: begin
					nxt_st.sel_in[`RPS_SEL_SENT2] = bus_req.wdata[`RPS_LO_BYTE];
				end
				default: begin
					// low field takes the lower pin number
					for (int j = 0; j < `RPS_NUM_OUT_REG; j++) begin
						if (bus_req.addr == 4'(`RPS_REG_OUT0 + j)) begin
							nxt_st.sel_out[2*j]   = bus_req.wdata[`RPS_OUT_LO];
							nxt_st.sel_out[2*j+1] = bus_req.wdata[`RPS_OUT_HI];
						end
					end
				end
			endcase
		end
		// read data stands for one cycle only
		nxt_st.rdata = bus_req.re ? reg_read(bus_req.addr, st_ff) : `RPS_RD_ZERO;
		// routing uses the stored selectors, so a write acts one cycle later
		for (int i = 0; i < `RPS_NUM_IN; i++) begin
			nxt_st.route[i] = in_route(st_ff.sel_in[i], remappable_pin,
				comparator_one_out);
		end
		for (int i = 0; i < `RPS_NUM_PIN; i++) begin
			nxt_st.pin_out[i] = out_route(st_ff.sel_out[i], periph_func);
			nxt_st.pin_oe[i]  = (st_ff.sel_out[i] != `RPS_FUNC_OFF);
		end
	end

	// state register, cleared at reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign bus_rdata  = st_ff.rdata;
	assign periph_in  = st_ff.route;
	assign out_pin    = st_ff.pin_out;
	assign out_pin_oe = st_ff.pin_oe;

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	sequence s_wr(logic [3:0] a);
		ce && bus_req.we && bus_req.addr == a;
	endsequence

	sequence s_rd(logic [3:0] a);
		ce && bus_req.re && !bus_req.we && bus_req.addr == a;
	endsequence

	a_gnd_route: assert property (
		ce && st_ff.sel_in[`RPS_SEL_CAN1] == `RPS_CODE_GND |=> !periph_in.can1_receive_in)
		else $error("ground code did not route zero");

	a_cmp_route: assert property (
		ce && st_ff.sel_in[`RPS_SEL_SPI2] == `RPS_CODE_CMP
		|=> periph_in.spi2_target_select_in == $past(comparator_one_out))
		else $error("comparator code not routed");

	a_pin_top_route: assert property (
		ce && st_ff.sel_in[`RPS_SEL_SENT1] == `RPS_CODE_MAX
		|=> periph_in.sent_rx_one_in == $past(remappable_pin[`RPS_NUM_RPIN-1]))
		else $error("top code not routed to pin 181");

	a_spi2_lane: assert property (
		s_wr(`RPS_REG_SPI2) ##1 s_rd(`RPS_REG_SPI2)
		|=> bus_rdata == {8'h00, $past(bus_req.wdata[`RPS_LO_BYTE], 2)})
		else $error("spi2 select readback wrong");

	a_sync_lane: assert property (
		s_wr(`RPS_REG_SYNC) ##1 s_rd(`RPS_REG_SYNC)
		|=> bus_rdata == {$past(bus_req.wdata[`RPS_HI_BYTE], 2), 8'h00})
		else $error("pwm sync readback wrong");

	a_dtc_pair: assert property (
		s_wr(`RPS_REG_DTC23) |=> st_ff.sel_in[`RPS_SEL_DTC3] == $past(bus_req.wdata[15:8])
		&& st_ff.sel_in[`RPS_SEL_DTC2] == $past(bus_req.wdata[7:0]))
		else $error("dead-time pair split wrong");

	a_out_unused: assert property (
		s_rd(`RPS_REG_OUT0) |=> bus_rdata[15:14] == 2'h0 && bus_rdata[7:6] == 2'h0)
		else $error("unimplemented output bits not zero");

	a_out_drive: assert property (
		ce && st_ff.sel_out[0] != `RPS_FUNC_OFF
		|=> out_pin_oe[0] && out_pin[0] == $past(periph_func[st_ff.sel_out[0]]))
		else $error("pin 20 not driven by its function");

	a_route_delay: assert property (
		s_wr(`RPS_REG_CAN1) ##1 (ce && st_ff.sel_in[`RPS_SEL_CAN1] == `RPS_CODE_GND)
		|=> !periph_in.can1_receive_in)
		else $error("new selector not routing one cycle later");

endmodule : rps_top

//--- dv/rps_partner.sv
// far-side model: remappable pin levels, comparator and peripheral functions
`timescale 1ns/100ps
module rps_partner (
	input  wire logic clock,  // bench clock
	input  wire logic nrst,   // async reset, low
	output logic [181:0] pins,  // pin levels by number
	output logic       cmp,   // comparator one level
	output logic [63:0] funcs  // output function levels by code
);
	// patterns move every cycle so a route one edge late shows up
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pins  <= '0;
			cmp   <= 1'b0;
			funcs <= '0;
		end else begin
			pins  <= {pins[180:0], ~(pins[181] ^ pins[90])};
			cmp   <= ~cmp;
			funcs <= {funcs[62:0], ~(funcs[63] ^ funcs[30])};
		end
	end
endmodule : rps_partner

//--- dv/remappable_pin_select_bench.sv
// self-checking bench of the pin remapper
`timescale 1ns/100ps
module remappable_pin_select_bench;
	logic                    clock = 1'b0;
	logic                    nrst = 1'b0;
	rps_pkg::rps_bus_req_t   bus_req = '0;
	logic [15:0]             bus_rdata;
	logic [181:0]            pins, s_pins;
	logic                    cmp, s_cmp, chk_on = 1'b0;
	logic [63:0]             funcs, s_funcs;
	rps_pkg::rps_periph_in_t periph_in;
	logic [7:0]              out_pin, out_pin_oe, e_in, e_pin, e_oe;
	logic [7:0][7:0]         m_in = '0, s_in;
	logic [7:0][5:0]         m_out = '0, s_out;
	logic [15:0]             m_reg [16] = '{default: 16'h0000};
	logic [7:0]              codes [5] = '{8'h00, 8'h01, 8'hB5, 8'hB6, 8'hFF};
	logic [31:0]             rnd = 32'hC71A8D1A;
	int                      miscompares = 0;
	int                      checks = 0;

	rps_top u_rps_top (.clock(clock), .nrst(nrst), .ce(1'b1), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .remappable_pin(pins), .comparator_one_out(cmp),
		.periph_func(funcs), .periph_in(periph_in), .out_pin(out_pin), .out_pin_oe(out_pin_oe));
	rps_partner u_rps_partner (.clock(clock), .nrst(nrst), .pins(pins), .cmp(cmp), .funcs(funcs));

	always #2 clock = ~clock;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// implemented bits of each register index
	function automatic logic [15:0] reg_mask(input logic [3:0] a);
		case (a)
			4'h0, 4'h1, 4'h6: return 16'h00FF;
			4'h2, 4'h3, 4'h5: return 16'hFF00;
			4'h4: return 16'hFFFF;
			4'h7, 4'h8, 4'h9, 4'hA: return 16'h3F3F;
			default: return 16'h0000;
		endcase
	endfunction : reg_mask

	function automatic logic route_in(input logic [7:0] c);
		if (c == 8'h01) return s_cmp;
		if (c > 8'h01 && c <= 8'hB5) return s_pins[c];
		return 1'b0;
	endfunction : route_in

	task automatic cmpv(input logic [23:0] got, input logic [23:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : cmpv

	// called just after a rising edge; leaves the strobe up so a request may follow at once
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		int p;
		bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clock);
		p = 2 * (int'(a) - 7);
		m_reg[a] = d & reg_mask(a);
		case (a)
			4'h0, 4'h1: m_in[a] = d[7:0];
			4'h2, 4'h3: m_in[a] = d[15:8];
			4'h4: m_in[5:4] = d;
			4'h5: m_in[6] = d[15:8];
			4'h6: m_in[7] = d[7:0];
			4'h7, 4'h8, 4'h9, 4'hA: begin
				m_out[p] = d[5:0];
				m_out[p + 1] = d[13:8];
			end
			default: p = 0;
		endcase
	endtask : wr

	// called just after a rising edge; data checked in the one cycle it stands
	task automatic rd(input logic [3:0] a);
		bus_req <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
		@(posedge clock);
		bus_req <= '0;
		@(negedge clock);
		cmpv({8'h00, bus_rdata}, {8'h00, m_reg[a]}, "read data");
		@(posedge clock);
	endtask : rd

	task automatic test_done();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// routing uses selectors and levels held one edge earlier
	always @(negedge clock) begin
		if (chk_on) begin
			for (int i = 0; i < 8; i++) begin
				e_in[i] = route_in(s_in[i]);
				e_oe[i] = (s_out[i] != 6'h00);
				e_pin[i] = e_oe[i] & s_funcs[s_out[i]];
			end
			cmpv({periph_in, out_pin, out_pin_oe}, {e_in, e_pin, e_oe}, "routing");
		end
		{s_pins, s_cmp, s_funcs, s_in, s_out} = {pins, cmp, funcs, m_in, m_out};
	end

	// watchdog against a hung run
	initial begin
		repeat (50000) @(posedge clock);
		miscompares++;
		test_done();
	end

	initial begin
		repeat (2) @(posedge clock);
		chk_on = 1'b1;
		repeat (18) @(posedge clock);
		nrst <= 1'b1;
		for (int a = 0; a < 16; a++) rd(4'(a));
		// corner codes in every field, then a pause for routing
		for (int k = 0; k < 5; k++) begin
			for (int a = 0; a < 11; a++) begin
				wr(4'(a), {2{codes[k]}});
				rd(4'(a));
				repeat (3) @(posedge clock);
			end
		end
		// random writes to any index, unmapped ones too
		for (int n = 0; n < 300; n++) begin
			rnd = lfsr(rnd);
			wr(rnd[3:0], rnd[31:16]);
			if (rnd[4])
				rd(rnd[3:0]);
		end
		bus_req <= '0;
		repeat (2) @(posedge clock);
		test_done();
	end
endmodule : remappable_pin_select_bench
